// *** bench/scc_ctrl_asserts.sv ***
// Port assertions for the clock and power control bank.
// Assumes a bind onto scc_ctrl; byte addresses 0x28, 0x40, 0x48, 0x60.
`timescale 1ns/1ps
module scc_ctrl_asserts (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              clk_en,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic              pslverr,
  input wire scc_pkg::scc_clk_t clk_ctl,
  input wire scc_pkg::scc_pwr_t pwr_ctl,
  input wire scc_pkg::scc_evt_t evt
);
  import scc_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic lock_r;
  logic lock_nxt;
  logic swr;
  logic hole;
  // Only aligned words decode; upper address bits ignored
  assign hole = !(paddr[7:0] inside {8'h28, 8'h40, 8'h48, 8'h60});
  assign swr = psel && penable && pwrite && clk_en && paddr[7:0] == 8'h48 && pstrb[1]
               && pwdata[15];
  sequence wr_s(a, lane);
    psel && penable && pwrite && clk_en && paddr[7:0] == a && pstrb[lane];
  endsequence
  // Lock mirror, cleared by software reset as well
  always_comb begin
    lock_nxt = lock_r;
    if (evt.software_reset_trigger)
      lock_nxt = 1'b0;
    else if (psel && penable && pwrite && clk_en && paddr[7:0] == 8'h40 && pstrb[0])
      lock_nxt = 1'b1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      lock_r <= 1'b0;
    else
      lock_r <= lock_nxt;
  end
  ck_sel_a: assert property (wr_s(8'h28, 0) |=>
    clk_ctl.system_clock_select == $past(pwdata[1:0])) else $error("select not written");
  ck_byp_a: assert property (wr_s(8'h28, 0) |=>
    clk_ctl.glitch_filter_bypass == $past(pwdata[3])) else $error("bypass not written");
  ck_off_a: assert property (wr_s(8'h28, 0) |=>
    clk_ctl.fast_crystal_enable == !$past(pwdata[2])) else $error("crystal enable wrong");
  ret_keep_a: assert property (wr_s(8'h40, 1) |=>
    pwr_ctl.retention_keep == $past(pwdata[11:8])) else $error("retention not written");
  pd_bits_a: assert property (wr_s(8'h40, 0) |=>
    pwr_ctl.radio_powerdown == $past(pwdata[2])
    && pwr_ctl.peripheral_powerdown == $past(pwdata[1])) else $error("sleep bits wrong");
  boost_win_a: assert property (pwr_ctl.dcdc_boost |-> !pwr_ctl.dcdc_buck)
    else $error("buck with boost");
  force_lock_a: assert property (lock_r && !swr && !evt.software_reset_trigger |=>
    $stable(pwr_ctl.dcdc_boost) && $stable(pwr_ctl.dcdc_buck)) else $error("lock broken");
  sys_bits_a: assert property (wr_s(8'h48, 0) |=>
    pwr_ctl.debug_port_enable == $past(pwdata[7])
    && pwr_ctl.prom_controller_reset == $past(pwdata[6])
    && pwr_ctl.pad_latch_open == $past(pwdata[5])) else $error("system bits wrong");
  slow_src_a: assert property (wr_s(8'h48, 0) |=>
    clk_ctl.slow_clock_source == $past(pwdata[3])) else $error("slow source wrong");
  bad_addr_a: assert property (psel && penable |-> pslverr == hole)
    else $error("error response wrong");
  sw_pulse_a: assert property (swr |=>
    evt.software_reset_trigger ##1 !evt.software_reset_trigger) else $error("no reset pulse");
  sw_clear_a: assert property (swr |-> ##2 pwr_ctl.radio_powerdown
    && pwr_ctl.peripheral_powerdown && pwr_ctl.retention_keep == 4'h0)
    else $error("power bits not reset");
endmodule // scc_ctrl_asserts

// *** bench/scc_ctrl_test.sv ***
// Self-checking bench for scc_ctrl over APB.
// Assumes shortened settle and timeout counts; checker bound at the foot.
`timescale 1ns/1ps
module scc_ctrl_test;
  import scc_pkg::*;
  localparam int SETTLE = 20;
  localparam int TMO    = 30;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err;
  logic        wakeup_event, psm_start, blocks_ready, trim_match;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0]  pstrb;
  scc_clk_t    clk_ctl;
  scc_pwr_t    pwr_ctl;
  scc_evt_t    evt;
  int          n_fail, check_count;
  scc_ctrl #(.SETTLE_CYCLES(SETTLE), .TIMEOUT_CYCLES(TMO)) scc_ctrl_inst (.pclk, .presetn,
    .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .wakeup_event, .psm_start, .blocks_ready, .trim_match, .clk_ctl, .pwr_ctl, .evt);
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // One transfer; the request holds until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= {16'hA5A5, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_fail++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, d);
    // Outputs change at the access edge; look at them one edge later
    @(posedge pclk);
  endtask
  task automatic rdx(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 16'h0);
    chk(nm, rd, e);
  endtask
  // Pulses last one cycle, so each edge is sampled
  task automatic wait_evt(input string nm, input int b, input int lo, input int hi);
    int n;
    for (n = 0; n < hi; n++) begin
      @(posedge pclk);
      #1;
      if (evt[b] === 1'b1)
        break;
    end
    if (n == hi) begin
      n_fail++;
      end_sim();
    end
    chk(nm, 32'(n >= lo), 32'h1);
  endtask
  task automatic t_reset();
    rdx("clk rst", 8'h28, 32'h80);
    rdx("pmu rst", 8'h40, 32'h6);
    rdx("sys rst", 8'h48, 32'h20);
    rdx("hole", 8'h2C, 32'h0);
    chk("hole err", {31'h0, err}, 32'h1);
    chk("clk out", {27'h0, clk_ctl}, 32'h10);
    clk_en <= 1'b0;
    wr(8'h40, 16'h0F00);
    clk_en <= 1'b1;
    rdx("frozen", 8'h40, 32'h6);
  endtask
  task automatic t_clk();
    for (int s = 0; s < 4; s++) begin
      wr(8'h28, 16'hFF18 | 16'(s));
      chk("sel out", {30'h0, clk_ctl.system_clock_select}, 32'(s));
      rdx("sel", 8'h28, 32'h8 | s | (s == 0 ? 32'h80 : s == 1 ? 32'h40 : 32'h20));
      chk("byp", {31'h0, clk_ctl.glitch_filter_bypass}, 32'h1);
    end
    // Crystal goes off on its off bit whatever the select; here RC is selected
    wr(8'h28, 16'h5);
    chk("off", {31'h0, clk_ctl.fast_crystal_enable}, 32'h0);
    rdx("stat off", 8'h60, 32'h0);
    wakeup_event <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("off wake", {31'h0, clk_ctl.fast_crystal_enable}, 32'h0);
    wakeup_event <= 1'b0;
    trim_match <= 1'b1;
    wr(8'h28, 16'h1);
    repeat (SETTLE - 8) @(posedge pclk);
    rdx("early", 8'h60, 32'h40);
    repeat (8) @(posedge pclk);
    rdx("settled", 8'h60, 32'hC0);
    wr(8'h28, 16'h0);
    rdx("on xtal", 8'h28, 32'h80);
  endtask
  task automatic t_pmu();
    wr(8'h40, 16'h41);
    rdx("buck", 8'h40, 32'h41);
    wakeup_event <= 1'b1;
    wait_evt("wake rst", 3, 2, 10);
    @(posedge pclk);
    wakeup_event <= 1'b0;
    wr(8'h40, 16'hFFFF);
    rdx("locked", 8'h40, 32'hF77);
    chk("div", {30'h0, pwr_ctl.copy_bus_div}, 32'h3);
    chk("ret", {28'h0, pwr_ctl.retention_keep}, 32'hF);
  endtask
  task automatic t_sys();
    wr(8'h48, 16'hFFFF);
    chk("sw rst", {31'h0, evt.software_reset_trigger}, 32'h1);
    rdx("sys kept", 8'h48, 32'h2F8);
    rdx("pmu clr", 8'h40, 32'h6);
    rdx("clk clr", 8'h28, 32'h80);
    chk("sys out", {26'h0, pwr_ctl[5:0]}, 32'h3F);
    chk("slow", {31'h0, clk_ctl.slow_clock_source}, 32'h1);
    wr(8'h40, 16'hC0);
    chk("boost", {30'h0, pwr_ctl.dcdc_boost, pwr_ctl.dcdc_buck}, 32'h2);
    wr(8'h48, 16'h210);
    chk("pad hold", {31'h0, pwr_ctl.pad_latch_open}, 32'h0);
    wakeup_event <= 1'b1;
    wait_evt("copy", 1, 2, 10);
    @(posedge pclk);
    wakeup_event <= 1'b0;
  endtask
  task automatic t_psm();
    psm_start <= 1'b1;
    for (int i = 0; i < TMO * 2; i++) begin
      @(posedge pclk);
      #1;
      if (evt.psm_proceed === 1'b1)
        chk("tmo off", 32'h1, 32'h0);
    end
    @(posedge pclk);
    blocks_ready <= 1'b1;
    wait_evt("ready", 0, 1, 8);
    @(posedge pclk);
    psm_start <= 1'b0;
    blocks_ready <= 1'b0;
    wr(8'h48, 16'h8000);
    repeat (4) @(posedge pclk);
    psm_start <= 1'b1;
    wait_evt("tmo", 0, TMO, TMO + 12);
  endtask
  initial begin
    n_fail = 0;
    check_count = 0;
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'h3;
    wakeup_event = 1'b0;
    psm_start = 1'b0;
    blocks_ready = 1'b0;
    trim_match = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_clk();
    t_pmu();
    t_sys();
    t_psm();
    end_sim();
  end
endmodule // scc_ctrl_test
bind scc_ctrl scc_ctrl_asserts scc_ctrl_asserts_inst (.pclk, .presetn, .clk_en, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .pslverr, .clk_ctl, .pwr_ctl, .evt);

// *** src/scc_ctrl.sv ***
// System clock and power control register bank with APB slave.
// Assumes APB on pclk; event inputs come from other domains and are synchronised.
`timescale 1ns/1ps

module scc_ctrl
  import scc_pkg::*;
#(
  parameter int SETTLE_CYCLES  = scc_pkg::SETTLE_CYC,
  parameter int TIMEOUT_CYCLES = scc_pkg::TIMEOUT_CYC
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clk_en,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [31:0]      paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             wakeup_event,
  input  wire logic             psm_start,
  input  wire logic             blocks_ready,
  input  wire logic             trim_match,
  output scc_pkg::scc_clk_t     clk_ctl,
  output scc_pkg::scc_pwr_t     pwr_ctl,
  output scc_pkg::scc_evt_t     evt
);
  import scc_pkg::*;

  localparam int NSYNC = 4;

  // Two-stage synchronisers; stage one feeds stage two only
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  logic [NSYNC-1:0] sync3_r;
  logic [NSYNC-1:0] async_in;

  assign async_in = {trim_match, blocks_ready, psm_start, wakeup_event};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          sync3_r[gi] <= 1'b0;
        end else if (clk_en) begin
          sync1_r[gi] <= async_in[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
        end
      end
    end
  endgenerate

  logic wake_pulse;
  logic start_pulse;
  logic ready_s;
  logic trim_s;

  assign wake_pulse  = sync2_r[0] & ~sync3_r[0];
  assign start_pulse = sync2_r[1] & ~sync3_r[1];
  assign ready_s     = sync2_r[2];
  assign trim_s      = sync2_r[3];

  // APB decode on low index bits
  logic [IDX_DEC_W-1:0] idx;
  logic                 hit_ck;
  logic                 hit_pm;
  logic                 hit_sy;
  logic                 hit_st;
  logic                 hit;
  logic                 wr;
  logic                 setup;
  logic [15:0]          wmask;

  assign idx    = paddr[IDX_DEC_W+1:2];
  assign hit_ck = (paddr[1:0] == 2'h0) && (idx == CLK_CTRL_IDX[IDX_DEC_W-1:0]);
  assign hit_pm = (paddr[1:0] == 2'h0) && (idx == PMU_CTRL_IDX[IDX_DEC_W-1:0]);
  assign hit_sy = (paddr[1:0] == 2'h0) && (idx == SYS_CTRL_IDX[IDX_DEC_W-1:0]);
  assign hit_st = (paddr[1:0] == 2'h0) && (idx == CLK_STAT_IDX[IDX_DEC_W-1:0]);
  assign hit    = hit_ck | hit_pm | hit_sy | hit_st;
  assign setup  = psel & ~penable;
  assign wr     = clk_en & psel & penable & pwrite & hit;
  assign wmask  = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  // Zero wait states; unmapped address answers with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // Register state
  logic [15:0]  ck_r;
  logic [15:0]  ck_nxt;
  logic [15:0]  pm_r;
  logic [15:0]  pm_nxt;
  logic [15:0]  sy_r;
  logic [15:0]  sy_nxt;
  logic         force_lock_r;
  logic         force_lock_nxt;
  logic [1:0]   active_sel_r;
  logic [1:0]   active_sel_nxt;
  logic [31:0]  prdata_r;
  logic [31:0]  prdata_nxt;
  scc_evt_t     evt_r;
  scc_evt_t     evt_nxt;
  logic         sw_rst;
  logic [15:0]  pm_w;

  assign sw_rst = wr & hit_sy & pstrb[1] & pwdata[SY_SWRST_BIT];

  always_comb begin
    ck_nxt         = ck_r;
    pm_nxt         = pm_r;
    sy_nxt         = sy_r;
    force_lock_nxt = force_lock_r;
    pm_w           = (pm_r & ~wmask) | (pwdata[15:0] & wmask);
    // Only writable bits take write data; the rest stay zero
    if (wr && hit_ck) begin
      ck_nxt = ((ck_r & ~wmask) | (pwdata[15:0] & wmask)) & CK_RW_MASK;
    end
    if (wr && hit_pm) begin
      pm_nxt = pm_w & PM_RW_MASK;
      if (force_lock_r) begin
        pm_nxt[PM_BOOST_BIT] = pm_r[PM_BOOST_BIT];
        pm_nxt[PM_BUCK_BIT]  = pm_r[PM_BUCK_BIT];
      end
      if (pstrb[0]) begin
        force_lock_nxt = 1'b1;
      end
    end
    if (wr && hit_sy) begin
      sy_nxt = ((sy_r & ~wmask) | (pwdata[15:0] & wmask)) & SY_RW_MASK;
    end
    // Software reset spares the system control register
    if (sw_rst) begin
      ck_nxt         = CK_RESET;
      pm_nxt         = PM_RESET;
      force_lock_nxt = 1'b0;
    end
  end

  // Active source follows the select; the switch is the mux's job
  always_comb begin
    active_sel_nxt = sw_rst ? SEL_XTAL : ck_r[CK_SEL_LSB +: 2];
  end

  // Crystal settling counter
  logic [CNT_W-1:0] settle_cnt_r;
  logic [CNT_W-1:0] settle_cnt_nxt;
  logic             settled_r;
  logic             settled_nxt;
  logic             xtal_on;

  assign xtal_on = ~ck_r[CK_XTAL_OFF_BIT];

  always_comb begin
    settle_cnt_nxt = settle_cnt_r;
    settled_nxt    = settled_r;
    if (!xtal_on || sw_rst) begin
      settle_cnt_nxt = '0;
      settled_nxt    = 1'b0;
    end else if (!settled_r) begin
      // Flag rises one cycle past the full time, so strictly more
      if (settle_cnt_r >= CNT_W'(SETTLE_CYCLES)) begin
        settled_nxt = 1'b1;
      end else begin
        settle_cnt_nxt = settle_cnt_r + 1'b1;
      end
    end
  end

  // Power sequence timeout
  scc_psm_t         psm_r;
  scc_psm_t         psm_nxt;
  logic [CNT_W-1:0] tmo_cnt_r;
  logic [CNT_W-1:0] tmo_cnt_nxt;
  logic             proceed;

  always_comb begin
    psm_nxt     = psm_r;
    tmo_cnt_nxt = tmo_cnt_r;
    proceed     = 1'b0;
    case (psm_r)
      PSM_IDLE: begin
        tmo_cnt_nxt = '0;
        if (start_pulse) begin
          psm_nxt = PSM_WAIT;
        end
      end
      PSM_WAIT: begin
        tmo_cnt_nxt = tmo_cnt_r + 1'b1;
        if (ready_s) begin
          proceed = 1'b1;
          psm_nxt = PSM_DONE;
        end else if (!sy_r[SY_TMO_DIS_BIT] &&
                     tmo_cnt_r >= CNT_W'(TIMEOUT_CYCLES - 1)) begin
          proceed = 1'b1;
          psm_nxt = PSM_DONE;
        end
      end
      PSM_DONE: begin
        psm_nxt = PSM_IDLE;
      end
      default: begin
        psm_nxt = PSM_IDLE;
      end
    endcase
    if (sw_rst) begin
      psm_nxt = PSM_IDLE;
    end
  end

  // One-cycle event outputs
  always_comb begin
    evt_nxt                        = '0;
    evt_nxt.hw_reset_req           = wake_pulse & pm_r[PM_WAKE_RST_BIT];
    evt_nxt.prom_copy_start        = wake_pulse & sy_r[SY_COPY_BIT];
    evt_nxt.software_reset_trigger = sw_rst;
    evt_nxt.psm_proceed            = proceed;
  end

  // Read data captured in setup so it is stable in access
  logic [15:0] ck_rd;
  logic [15:0] st_rd;

  always_comb begin
    ck_rd                  = ck_r;
    ck_rd[CK_XTAL_BIT]     = (active_sel_r == SEL_XTAL);
    ck_rd[CK_RC_BIT]       = (active_sel_r == SEL_RC);
    ck_rd[CK_SLOW_BIT]     = active_sel_r[1];
    st_rd                  = '0;
    st_rd[ST_SETTLED_BIT]  = settled_r;
    st_rd[ST_TRIM_BIT]     = trim_s;
    prdata_nxt             = prdata_r;
    if (setup) begin
      prdata_nxt = '0;
      if (hit_ck) begin
        prdata_nxt[15:0] = ck_rd;
      end else if (hit_pm) begin
        prdata_nxt[15:0] = pm_r;
      end else if (hit_sy) begin
        prdata_nxt[15:0] = sy_r;
      end else if (hit_st) begin
        prdata_nxt[15:0] = st_rd;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_r         <= CK_RESET;
      pm_r         <= PM_RESET;
      sy_r         <= SY_RESET;
      force_lock_r <= 1'b0;
      active_sel_r <= SEL_XTAL;
      settle_cnt_r <= '0;
      settled_r    <= 1'b0;
      psm_r        <= PSM_IDLE;
      tmo_cnt_r    <= '0;
      evt_r        <= '0;
      prdata_r     <= '0;
    end else if (clk_en) begin
      ck_r         <= ck_nxt;
      pm_r         <= pm_nxt;
      sy_r         <= sy_nxt;
      force_lock_r <= force_lock_nxt;
      active_sel_r <= active_sel_nxt;
      settle_cnt_r <= settle_cnt_nxt;
      settled_r    <= settled_nxt;
      psm_r        <= psm_nxt;
      tmo_cnt_r    <= tmo_cnt_nxt;
      evt_r        <= evt_nxt;
      prdata_r     <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;
  assign evt    = evt_r;

  // Control outputs from register bits; crystal enable is the inverted off bit, buck is masked by boost
  assign clk_ctl.fast_crystal_enable  = xtal_on;
  assign clk_ctl.glitch_filter_bypass = ck_r[CK_FLT_BYP_BIT];
  assign clk_ctl.system_clock_select  = ck_r[CK_SEL_LSB +: 2];
  assign clk_ctl.slow_clock_source    = sy_r[SY_SLOW_SRC_BIT];

  assign pwr_ctl.retention_keep        = pm_r[PM_RET_LSB +: 4];
  assign pwr_ctl.dcdc_boost            = pm_r[PM_BOOST_BIT];
  assign pwr_ctl.dcdc_buck             = pm_r[PM_BUCK_BIT] & ~pm_r[PM_BOOST_BIT];
  assign pwr_ctl.copy_bus_div          = pm_r[PM_DIV_LSB +: 2];
  assign pwr_ctl.radio_powerdown       = pm_r[PM_RADIO_BIT];
  assign pwr_ctl.peripheral_powerdown  = pm_r[PM_PERI_BIT];
  assign pwr_ctl.timeout_disable       = sy_r[SY_TMO_DIS_BIT];
  assign pwr_ctl.debug_port_enable     = sy_r[SY_DBG_BIT];
  assign pwr_ctl.prom_controller_reset = sy_r[SY_PROM_RST_BIT];
  assign pwr_ctl.pad_latch_open        = sy_r[SY_PAD_BIT];

endmodule // scc_ctrl

// *** src/scc_pkg.sv ***
// Package for the system clock and power control register bank.
// Assumes a 200 MHz APB clock; all users import the whole package.
package scc_pkg;

  // Register indexes as printed; byte address is four times the index
  localparam logic [31:0] CLK_CTRL_IDX     = 32'h5000000A;
  localparam logic [31:0] PMU_CTRL_IDX     = 32'h50000010;
  localparam logic [31:0] SYS_CTRL_IDX     = 32'h50000012;
  localparam logic [31:0] CLK_STAT_IDX     = 32'h50000018;
  localparam int          IDX_DEC_W        = 6;

  // Clock source control fields
  localparam int          CK_SEL_LSB       = 0;
  localparam int          CK_XTAL_OFF_BIT  = 2;
  localparam int          CK_FLT_BYP_BIT   = 3;
  localparam int          CK_SLOW_BIT      = 5;
  localparam int          CK_RC_BIT        = 6;
  localparam int          CK_XTAL_BIT      = 7;
  localparam logic [1:0]  SEL_XTAL         = 2'h0;
  localparam logic [1:0]  SEL_RC           = 2'h1;

  // Power unit control fields
  localparam int          PM_WAKE_RST_BIT  = 0;
  localparam int          PM_PERI_BIT      = 1;
  localparam int          PM_RADIO_BIT     = 2;
  localparam int          PM_DIV_LSB       = 4;
  localparam int          PM_BUCK_BIT      = 6;
  localparam int          PM_BOOST_BIT     = 7;
  localparam int          PM_RET_LSB       = 8;
  localparam logic [15:0] PM_RW_MASK       = 16'h0FF7;
  localparam logic [15:0] PM_RESET         = 16'h0006;

  // System control fields, then the clock control mask and reset value
  localparam int          SY_SLOW_SRC_BIT  = 3;
  localparam int          SY_COPY_BIT      = 4;
  localparam int          SY_PAD_BIT       = 5;
  localparam int          SY_PROM_RST_BIT  = 6;
  localparam int          SY_DBG_BIT       = 7;
  localparam int          SY_TMO_DIS_BIT   = 9;
  localparam int          SY_SWRST_BIT     = 15;
  localparam logic [15:0] SY_RW_MASK       = 16'h02F8;
  localparam logic [15:0] SY_RESET         = 16'h0020;
  localparam logic [15:0] CK_RW_MASK       = 16'h000F;
  localparam logic [15:0] CK_RESET         = 16'h0000;

  // Status register of own layout
  localparam int          ST_TRIM_BIT      = 6;
  localparam int          ST_SETTLED_BIT   = 7;

  // Timing
  localparam int          CLK_PERIOD_PS    = 5000;
  localparam int          XTAL_SETTLE_US   = 2000;
  localparam int          PSM_TIMEOUT_US   = 2000;
  // Microseconds to picoseconds before dividing by the period in picoseconds
  localparam int          SETTLE_CYC       = (XTAL_SETTLE_US * 1000000 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;
  localparam int          TIMEOUT_CYC      = (PSM_TIMEOUT_US * 1000000) / CLK_PERIOD_PS;
  localparam int          CNT_W            = 20;

  typedef enum logic [1:0] {
    PSM_IDLE = 2'b00,
    PSM_WAIT = 2'b01,
    PSM_DONE = 2'b11
  } scc_psm_t;

  typedef struct packed {
    logic       fast_crystal_enable;
    logic       glitch_filter_bypass;
    logic [1:0] system_clock_select;
    logic       slow_clock_source;
  } scc_clk_t;

  typedef struct packed {
    logic [3:0] retention_keep;
    logic       dcdc_boost;
    logic       dcdc_buck;
    logic [1:0] copy_bus_div;
    logic       radio_powerdown;
    logic       peripheral_powerdown;
    logic       timeout_disable;
    logic       debug_port_enable;
    logic       prom_controller_reset;
    logic       pad_latch_open;
  } scc_pwr_t;

  typedef struct packed {
    logic hw_reset_req;
    logic software_reset_trigger;
    logic prom_copy_start;
    logic psm_proceed;
  } scc_evt_t;

endpackage
